// [store_pkg.sv]
// shared constants and types for the guarded store datapath
package store_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int DISP_W = 7;
  // word displacement field counts words, so it is scaled by four
  localparam int WORD_DISP_SHIFT = 2;
  localparam logic [1:0] LANE_SWAP_LITTLE = 2'h3;
  localparam logic [1:0] LANE_SWAP_BIG = 2'h0;
  localparam logic [1:0] WORD_ALIGN_BITS = 2'h0;
  localparam logic [3:0] BE_FULL_WORD = 4'hF;
  localparam logic [3:0] BE_ONE_BYTE = 4'h1;
  localparam logic [31:0] MMIO_BASE_DEFAULT = 32'hF000_0000;
  localparam logic [31:0] MMIO_SIZE_DEFAULT = 32'h0020_0000;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [3:0] RST_BE = 4'h0;
  typedef enum logic [1:0] {
    OP_STORE_WORD,
    OP_STORE_WORD_DISPLACED,
    OP_STORE_BYTE,
    OP_STORE_BYTE_DISPLACED
  } store_op_t;
endpackage

// [store_fmt_if.sv]
// carrier between the store unit and its lane formatter
`timescale 1ns/10ps
`default_nettype none
interface store_fmt_if;
  import store_pkg::*;
  logic [ADDR_W-1:0] ea;
  logic [DATA_W-1:0] data;
  logic is_word;
  logic little;
  logic mmio;
  logic [LANES-1:0] be;
  logic [DATA_W-1:0] wdata;
  logic misaligned;
  modport fmt (input ea, data, is_word, little, mmio, output be, wdata, misaligned);
  modport user (output ea, data, is_word, little, mmio, input be, wdata, misaligned);
endinterface
`default_nettype wire

// [store_lane_formatter.sv]
// byte lane placement and alignment check for one store
`timescale 1ns/10ps
`default_nettype none
module store_lane_formatter (
  store_fmt_if.fmt f
);
  import store_pkg::*;
  wire [1:0] offset = f.ea[1:0];
  // mmio words ignore byte order, always native lane order
  wire [1:0] swap = (f.little || f.mmio) ? LANE_SWAP_LITTLE : LANE_SWAP_BIG;
  wire [LANES-1:0] byte_hit;
  genvar k;
  generate
    for (k = 0; k < LANES; k++) begin : g_lane
      // lane k holds the byte at address offset k
      wire [1:0] lane_idx = 2'(k);
      wire [1:0] word_src = 2'(LANES - 1) - (lane_idx ^ swap);
      assign byte_hit[k] = (offset == lane_idx);
      assign f.wdata[8*k +: 8] = f.is_word ? f.data[8*word_src +: 8] :
                                 f.data[7:0];
    end
  endgenerate
  assign f.be = f.is_word ? BE_FULL_WORD : byte_hit;
  assign f.misaligned = f.is_word && (offset != WORD_ALIGN_BITS);
endmodule
`default_nettype wire

// [guarded_store_unit.sv]
// guarded word and byte store unit with misaligned-store flag and trap request
//
// What this block does
// - word store writes all four data bytes
// - word byte order follows order select bit
// - word address adds signed displacement times four
// - misaligned word store sets the sticky flag
// - misaligned store with trap enable set requests trap at next jump
// - mmio word stores ignore byte order select
// - guard bit one writes unless the word store is misaligned, zero does not
// - false guard causes no side effect whatsoever
// - byte store writes low data byte only
// - undisplaced forms equal displacement of zero
// - byte address adds signed displacement
`timescale 1ns/10ps
`default_nettype none
module guarded_store_unit #(
  parameter logic [31:0] MMIO_BASE = store_pkg::MMIO_BASE_DEFAULT,
  parameter logic [31:0] MMIO_SIZE = store_pkg::MMIO_SIZE_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic issue_valid,
  input wire store_pkg::store_op_t issue_op,
  input wire logic [store_pkg::DISP_W-1:0] disp_field,
  input wire logic [store_pkg::DATA_W-1:0] guard_value,
  input wire logic [store_pkg::ADDR_W-1:0] address_operand,
  input wire logic [store_pkg::DATA_W-1:0] data_operand,
  input wire logic byte_order_select_bit,
  input wire logic misaligned_store_trap_enable,
  input wire logic misaligned_flag_clear,
  input wire logic interruptible_jump,
  output logic mem_valid,
  output logic [store_pkg::ADDR_W-1:0] mem_addr,
  output logic [store_pkg::LANES-1:0] mem_be,
  output logic [store_pkg::DATA_W-1:0] mem_wdata,
  output logic mem_is_mmio,
  output logic misaligned_store_flag,
  output logic trap_request
);
  import store_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // decode and effective address
  wire guard_true = guard_value[0];
  wire take = issue_valid && guard_true;
  wire op_word = (issue_op == OP_STORE_WORD) || (issue_op == OP_STORE_WORD_DISPLACED);
  wire op_displaced = (issue_op == OP_STORE_WORD_DISPLACED) ||
                      (issue_op == OP_STORE_BYTE_DISPLACED);
  // undisplaced forms run the displaced path with a zero offset
  wire [DISP_W-1:0] disp_used = op_displaced ? disp_field : '0;
  wire [ADDR_W-1:0] word_offset = {{(ADDR_W-DISP_W-WORD_DISP_SHIFT){disp_used[DISP_W-1]}},
                                   disp_used, 2'h0};
  wire [ADDR_W-1:0] byte_offset = {{(ADDR_W-DISP_W){disp_used[DISP_W-1]}},
                                   disp_used};
  wire [ADDR_W-1:0] ea = address_operand + (op_word ? word_offset : byte_offset);
  wire [ADDR_W-1:0] mmio_rel = ea - MMIO_BASE;
  wire in_mmio = (ea >= MMIO_BASE) && (mmio_rel < MMIO_SIZE);

  ////////////////////////////////////////////////////////////////////////
  // lane formatting
  store_fmt_if fmt_bus ();
  assign fmt_bus.ea = ea;
  assign fmt_bus.data = data_operand;
  assign fmt_bus.is_word = op_word;
  assign fmt_bus.little = byte_order_select_bit;
  // byte stores never swap, so mmio only matters for words
  assign fmt_bus.mmio = in_mmio && op_word;
  store_lane_formatter u_fmt (
    .f(fmt_bus.fmt)
  );
  // a misaligned word has no defined result; it is dropped rather than
  // risk a partial write straddling two words
  wire write_ok = take && !fmt_bus.misaligned;
  wire mis_event = take && fmt_bus.misaligned;

  ////////////////////////////////////////////////////////////////////////
  // memory request register
  logic mem_valid_reg;
  logic [ADDR_W-1:0] mem_addr_reg;
  logic [LANES-1:0] mem_be_reg;
  logic [DATA_W-1:0] mem_wdata_reg;
  logic mem_is_mmio_reg;
  // address and data hold on false guards so nothing downstream toggles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_valid_reg <= RST_FLAG;
      mem_addr_reg <= RST_WORD;
      mem_be_reg <= RST_BE;
      mem_wdata_reg <= RST_WORD;
      mem_is_mmio_reg <= RST_FLAG;
    end else begin
      mem_valid_reg <= write_ok;
      if (write_ok) begin
        mem_addr_reg <= ea;
        mem_be_reg <= fmt_bus.be;
        mem_wdata_reg <= fmt_bus.wdata;
        mem_is_mmio_reg <= in_mmio;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // misaligned flag and trap request
  logic mis_flag_reg;
  logic mis_flag_next;
  logic trap_pending_reg;
  logic trap_pending_next;
  logic trap_request_reg;
  // a new event wins over a clear in the same cycle
  assign mis_flag_next = mis_event | (mis_flag_reg & ~misaligned_flag_clear);
  wire trap_fire = trap_pending_reg && interruptible_jump;
  assign trap_pending_next = (mis_event && misaligned_store_trap_enable) |
                             (trap_pending_reg & ~trap_fire);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mis_flag_reg <= RST_FLAG;
      trap_pending_reg <= RST_FLAG;
      trap_request_reg <= RST_FLAG;
    end else begin
      mis_flag_reg <= mis_flag_next;
      trap_pending_reg <= trap_pending_next;
      trap_request_reg <= trap_fire;
    end
  end

  assign mem_valid = mem_valid_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_be = mem_be_reg;
  assign mem_wdata = mem_wdata_reg;
  assign mem_is_mmio = mem_is_mmio_reg;
  assign misaligned_store_flag = mis_flag_reg;
  assign trap_request = trap_request_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  wire [ADDR_W-1:0] exp_word_ea = address_operand +
                                  {{(ADDR_W-DISP_W-2){disp_field[DISP_W-1]}}, disp_field, 2'h0};
  wire [ADDR_W-1:0] exp_byte_ea = address_operand + {{(ADDR_W-DISP_W){disp_field[DISP_W-1]}},
                                                     disp_field};
  wire aligned_word_in = issue_valid && guard_value[0] && op_word && (ea[1:0] == 2'h0);
  wire byte_in = issue_valid && guard_value[0] && !op_word;

  chk_guard_blocks_write: assert property (
    @(posedge clk) disable iff (!rst_n)
    issue_valid && !guard_value[0] |=> !mem_valid)
    else $error("store issued under false guard");

  chk_guard_no_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    !misaligned_store_flag && !(issue_valid && guard_value[0]) |=> !misaligned_store_flag)
    else $error("flag rose without a guarded store");

  chk_word_full_lanes: assert property (
    @(posedge clk) disable iff (!rst_n)
    aligned_word_in |=> mem_valid && mem_be == 4'hF)
    else $error("word store did not write four bytes");

  chk_big_endian_order: assert property (
    @(posedge clk) disable iff (!rst_n)
    aligned_word_in && !byte_order_select_bit && !in_mmio
    |=> mem_wdata == {$past(data_operand[7:0]), $past(data_operand[15:8]),
                      $past(data_operand[23:16]), $past(data_operand[31:24])})
    else $error("big endian lane order wrong");

  chk_little_endian_order: assert property (
    @(posedge clk) disable iff (!rst_n)
    aligned_word_in && byte_order_select_bit |=> mem_wdata == $past(data_operand))
    else $error("little endian lane order wrong");

  chk_mmio_ignores_order: assert property (
    @(posedge clk) disable iff (!rst_n)
    aligned_word_in && in_mmio |=> mem_is_mmio && mem_wdata == $past(data_operand))
    else $error("mmio word store swapped bytes");

  chk_word_disp_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    aligned_word_in && issue_op == OP_STORE_WORD_DISPLACED |=> mem_addr == $past(exp_word_ea))
    else $error("displaced word address wrong");

  chk_byte_disp_addr: assert property (
    @(posedge clk) disable iff (!rst_n)
    byte_in && issue_op == OP_STORE_BYTE_DISPLACED |=> mem_addr == $past(exp_byte_ea))
    else $error("displaced byte address wrong");

  chk_undisplaced_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    issue_valid && guard_value[0] && issue_op == OP_STORE_BYTE
    |=> mem_addr == $past(address_operand))
    else $error("undisplaced store used a displacement");

  chk_undisplaced_word: assert property (
    @(posedge clk) disable iff (!rst_n)
    aligned_word_in && issue_op == OP_STORE_WORD |=> mem_addr == $past(address_operand))
    else $error("undisplaced word store used a displacement");

  // lane follows the final byte address, so displaced bytes are covered too
  chk_byte_one_lane: assert property (
    @(posedge clk) disable iff (!rst_n)
    byte_in |=> mem_valid && mem_be == (BE_ONE_BYTE << mem_addr[1:0])
                && mem_wdata == {4{$past(data_operand[7:0])}})
    else $error("byte store lane or data wrong");

  chk_misalign_sets_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    issue_valid && guard_value[0] && op_word && ea[1:0] != 2'h0
    |=> misaligned_store_flag && !mem_valid)
    else $error("misaligned word store not flagged");

  chk_flag_sticky: assert property (
    @(posedge clk) disable iff (!rst_n)
    misaligned_store_flag && !misaligned_flag_clear |=> misaligned_store_flag)
    else $error("misaligned flag dropped without clear");

  chk_trap_at_jump: assert property (
    @(posedge clk) disable iff (!rst_n)
    mis_event && misaligned_store_trap_enable ##1 interruptible_jump |=> trap_request)
    else $error("trap not requested at interruptible jump");

  // a quiet cycle between event and jump must not lose the pending request
  chk_trap_late_jump: assert property (
    @(posedge clk) disable iff (!rst_n)
    mis_event && misaligned_store_trap_enable ##1 !interruptible_jump ##1 interruptible_jump
    |=> trap_request)
    else $error("trap not requested at a later jump");

  cov_word_store: cover property (@(posedge clk) disable iff (!rst_n) aligned_word_in);
  cov_byte_displaced: cover property (@(posedge clk) disable iff (!rst_n)
    byte_in && issue_op == OP_STORE_BYTE_DISPLACED);
  cov_mmio_word: cover property (@(posedge clk) disable iff (!rst_n) aligned_word_in && in_mmio);
  cov_trap: cover property (@(posedge clk) disable iff (!rst_n) trap_request);
  cov_misaligned: cover property (@(posedge clk) disable iff (!rst_n) mis_event);
endmodule
`default_nettype wire

// [store_mem_model.sv]
// byte-addressed memory standing behind the store unit
`timescale 1ns/10ps
`default_nettype none
module store_mem_model (
  input wire logic clk,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_is_mmio
);
  logic [7:0] mem [logic [31:0]];
  int wcount = 0;
  logic last_mmio = 1'b0;
  ////////////////////////////////////////////////////////////////
  // no ready line: every request is taken on the edge it shows
  always @(posedge clk) begin
    if (mem_valid) begin
      wcount++;
      last_mmio = mem_is_mmio;
      for (int k = 0; k < 4; k++) begin
        if (mem_be[k]) begin
          mem[{mem_addr[31:2], 2'(k)}] = mem_wdata[8*k+:8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// [guarded_store_unit_tb.sv]
// self-checking bench for the guarded store unit
`timescale 1ns/10ps
`default_nettype none
module guarded_store_unit_tb;
  import store_pkg::*;
  logic clk, rst_n, issue_valid, osel, trap_en, fclr, jump;
  logic mem_valid, mem_is_mmio, flag, trap;
  store_op_t op;
  logic [6:0] disp;
  logic [31:0] guard, addr, data, mem_addr, mem_wdata;
  logic [3:0] mem_be;
  int fails = 0;
  int num_checks = 0;
  guarded_store_unit dut_u (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
    .issue_op(op), .disp_field(disp), .guard_value(guard), .address_operand(addr),
    .data_operand(data), .byte_order_select_bit(osel), .misaligned_store_trap_enable(trap_en),
    .misaligned_flag_clear(fclr), .interruptible_jump(jump), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_is_mmio(mem_is_mmio),
    .misaligned_store_flag(flag), .trap_request(trap));
  store_mem_model mem_u (.clk(clk), .mem_valid(mem_valid), .mem_addr(mem_addr),
    .mem_be(mem_be), .mem_wdata(mem_wdata), .mem_is_mmio(mem_is_mmio));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // upper guard bits set on purpose: only bit 0 may matter
  task automatic issue(input store_op_t o, input logic [6:0] d, input logic g,
      input logic [31:0] a, input logic [31:0] v);
    @(posedge clk); #1;
    issue_valid = 1'b1;
    op = o;
    disp = d;
    guard = {31'h2AAA_AAAA, g};
    addr = a;
    data = v;
    @(posedge clk); #1;
    issue_valid = 1'b0;
    @(posedge clk); #1;
  endtask
  task automatic tick;
    @(posedge clk); #1;
  endtask
  // lowest address lands in the top byte of the result
  function automatic logic [31:0] rd32(input logic [31:0] a);
    return {mem_u.mem[a], mem_u.mem[a+1], mem_u.mem[a+2], mem_u.mem[a+3]};
  endfunction
  task automatic byte_case(input store_op_t o, input logic [6:0] d, input logic [31:0] a,
      input logic [31:0] v, input logic [31:0] ea, input logic [3:0] be);
    issue(o, d, 1'b1, a, v);
    chk(mem_addr, ea, "byte addr");
    chk(mem_be, be, "byte lane");
    chk(mem_u.mem[ea], v[7:0], "byte data");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_word;
    int n;
    for (int b = 0; b < 2; b++) begin
      osel = b[0];
      n = mem_u.wcount;
      issue(OP_STORE_WORD, 7'h7F, 1'b1, 32'h0000_0D00, 32'h4433_2211);
      chk(32'(mem_u.wcount - n), 32'h1, "one write per store");
      chk(rd32(32'h0000_0D00), b ? 32'h1122_3344 : 32'h4433_2211, "word order");
      chk(mem_be, 4'hF, "word lanes");
      chk(mem_is_mmio, 1'b0, "not mmio");
    end
    $display("word store test done");
  endtask
  task automatic t_disp;
    osel = 1'b0;
    issue(OP_STORE_WORD_DISPLACED, 7'h01, 1'b1, 32'h0000_0CFC, 32'hAABB_CCDD);
    chk(rd32(32'h0000_0D00), 32'hAABB_CCDD, "disp plus four");
    issue(OP_STORE_WORD_DISPLACED, 7'h40, 1'b1, 32'h0000_1100, 32'h0102_0304);
    chk(mem_addr, 32'h0000_1000, "disp lowest");
    issue(OP_STORE_WORD_DISPLACED, 7'h3F, 1'b1, 32'h0000_1000, 32'h0506_0708);
    chk(rd32(32'h0000_10FC), 32'h0506_0708, "disp highest");
    $display("displaced word test done");
  endtask
  task automatic t_byte;
    for (int b = 0; b < 2; b++) begin
      osel = b[0];
      byte_case(OP_STORE_BYTE_DISPLACED, 7'h7C, 32'h0D02, 32'hAABB_CCDD, 32'h0CFE, 4'h4);
      byte_case(OP_STORE_BYTE_DISPLACED, 7'h40, 32'h4040, 32'h0000_0055, 32'h4000, 4'h1);
      byte_case(OP_STORE_BYTE_DISPLACED, 7'h3F, 32'h4000, 32'h0000_0066, 32'h403F, 4'h8);
      byte_case(OP_STORE_BYTE, 7'h3F, 32'h5001, 32'h1234_5677, 32'h5001, 4'h2);
    end
    $display("byte store test done");
  endtask
  // enable on, then off: the flag must rise either way, the trap only once
  task automatic t_misalign;
    int n;
    for (int e = 1; e >= 0; e--) begin
      trap_en = e[0];
      n = mem_u.wcount;
      issue(OP_STORE_WORD_DISPLACED, 7'h01, 1'b1, 32'h0000_0D02, 32'h1111_1111);
      chk(flag, 1'b1, "flag set");
      chk(32'(mem_u.wcount - n), 32'h0, "misaligned dropped");
      jump = 1'b1;
      tick();
      jump = 1'b0;
      chk(trap, e[0], "trap at jump");
      tick();
      chk(trap, 1'b0, "trap one cycle");
      chk(flag, 1'b1, "flag sticky");
      fclr = 1'b1;
      tick();
      fclr = 1'b0;
      chk(flag, 1'b0, "flag cleared");
    end
    $display("misaligned test done");
  endtask
  task automatic t_guard;
    int n;
    logic [31:0] last;
    n = mem_u.wcount;
    last = mem_addr;
    trap_en = 1'b1;
    issue(OP_STORE_WORD, 7'h00, 1'b0, 32'h0000_0D01, 32'hAABB_CCDD);
    issue(OP_STORE_BYTE, 7'h00, 1'b0, 32'h0000_0D00, 32'hAABB_CCDD);
    jump = 1'b1;
    tick();
    jump = 1'b0;
    chk(32'(mem_u.wcount - n), 32'h0, "guard false write");
    chk(mem_addr, last, "guard false addr");
    chk(flag, 1'b0, "guard false flag");
    chk(trap, 1'b0, "guard false trap");
    $display("guard test done");
  endtask
  // reset in mid-run must drop the sticky flag and a pending trap
  task automatic t_reset;
    trap_en = 1'b1;
    issue(OP_STORE_WORD, 7'h00, 1'b1, 32'h0000_0D01, 32'h0000_0000);
    chk(flag, 1'b1, "flag before reset");
    rst_n = 1'b0;
    tick();
    tick();
    rst_n = 1'b1;
    chk({mem_valid, flag, trap}, 32'h0, "mid reset outputs");
    chk(mem_addr, 32'h0, "mid reset addr");
    jump = 1'b1;
    tick();
    jump = 1'b0;
    chk(trap, 1'b0, "no trap after reset");
    $display("reset test done");
  endtask
  // only word stores go to the aperture, as software must
  task automatic t_mmio;
    for (int b = 0; b < 2; b++) begin
      osel = b[0];
      issue(OP_STORE_WORD, 7'h00, 1'b1, 32'hF000_0010, 32'h4433_2211);
      chk(mem_is_mmio, 1'b1, "mmio seen");
      chk(mem_u.last_mmio, 1'b1, "mmio at memory");
      chk(rd32(32'hF000_0010), 32'h1122_3344, "mmio order");
    end
    $display("mmio test done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    issue_valid = 1'b0;
    op = OP_STORE_WORD;
    disp = 7'h00;
    guard = 32'h0;
    addr = 32'h0;
    data = 32'h0;
    osel = 1'b0;
    trap_en = 1'b0;
    fclr = 1'b0;
    jump = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({mem_valid, flag, trap}, 32'h0, "reset outputs");
    t_word();
    t_disp();
    t_byte();
    t_misalign();
    t_guard();
    t_reset();
    t_mmio();
    finish_test();
  end
endmodule
`default_nettype wire
